// *** sipo_latch_map.svh ***
// register positions, widths and reset values for the serial-in parallel-out latch
`ifndef SIPO_LATCH_MAP_SVH
`define SIPO_LATCH_MAP_SVH

`define SIPO_STAGES      8
`define SIPO_FIRST       0
`define SIPO_SIXTH       5
`define SIPO_SEVENTH     6
`define SIPO_LAST        7
`define SIPO_RESET_VAL   8'h00
`define SIPO_OE_OFF      8'h00
`define SIPO_OE_ON       8'hFF

`endif

// *** sipo_latch_pkg.sv ***
// types shared by the serial-in parallel-out latch
`default_nettype none
`include "sipo_latch_map.svh"

package sipo_latch_pkg;

    // eight shift stages or eight latch bits, bit 0 is the first stage
    typedef logic [`SIPO_STAGES-1:0] stage_vec_t;

    // controller pins, all but output_enable sampled on clk; output_enable gates the drivers directly
    typedef struct packed {
        logic serial_in;        // serial data bit
        logic shift_clock;      // shift clock level
        logic hold_latch_load;  // strobe: latch follows stages while high
        logic output_enable;    // parallel outputs driven while high
    } pin_in_s;

endpackage
`default_nettype wire

// *** serial_in_parallel_out_latch.sv ***
// eight-stage shift register with holding latch, three-state parallel and cascade outputs
//
// Function
// [R01] rising shift clock shifts input into stage one
// [R02] rising edge moves stage seven into eight
// [R03] fast cascade shows stage seven's old value
// [R04] slow cascade copies fast on falling edge
// [R05] strobe high: latch follows; low: latch holds
// [R06] enable high drives latch onto parallel outputs
// [R07] enable low floats parallel outputs, cascades driven
// [R08] enable never changes stages or latch
// [R09] controller picks fast or slow cascade output
// [R10] no power-up state: shift, strobe, then enable
`timescale 1ns/100ps
`default_nettype none
`include "sipo_latch_map.svh"

module serial_in_parallel_out_latch (
    input  wire logic                      clk,
    input  wire logic                      reset_n,
    input  wire sipo_latch_pkg::pin_in_s   pins,
    output logic [`SIPO_STAGES-1:0]        parallel_outputs,
    output logic [`SIPO_STAGES-1:0]        parallel_outputs_oe,
    output logic                           fast_cascade_out,
    output logic                           slow_cascade_out
);

    // ==========================================================
    // edge helpers
    // ==========================================================
    // the shift clock is an ordinary sampled input, so edges are found
    // against its value one clk earlier; it must stay stable >= 1 clk per phase
    function automatic logic rose(input logic now_v, input logic was_v);
        rose = now_v & ~was_v;
    endfunction

    function automatic logic fell(input logic now_v, input logic was_v);
        fell = ~now_v & was_v;
    endfunction

    // ==========================================================
    // state
    // ==========================================================
    sipo_latch_pkg::stage_vec_t stage_q;    // shift stages, bit 0 first
    sipo_latch_pkg::stage_vec_t stage_d;
    sipo_latch_pkg::stage_vec_t hold_q;     // holding latch
    sipo_latch_pkg::stage_vec_t hold_d;
    logic                       clk_seen_q; // shift clock one clk ago
    logic                       slow_q;     // slow cascade flop
    logic                       slow_d;
    logic                       sc_rise;    // rising shift-clock edge seen
    logic                       sc_fall;    // falling shift-clock edge seen

    // ==========================================================
    // next-state logic
    // ==========================================================
    // output enable is deliberately absent here: it only gates the drivers
    always_comb begin // [R08]
        sc_rise = rose(pins.shift_clock, clk_seen_q);
        sc_fall = fell(pins.shift_clock, clk_seen_q);
        stage_d = stage_q;
        hold_d  = hold_q;
        slow_d  = slow_q;
        if (sc_rise) begin
            // new bit enters stage one, each stage moves up, stage seven into eight
            stage_d = {stage_q[`SIPO_LAST-1:`SIPO_FIRST], pins.serial_in}; // [R01] [R02]
        end
        if (sc_fall) begin
            // slow cascade picks up what the fast one took half a period earlier
            slow_d = stage_q[`SIPO_LAST]; // [R04]
        end
        if (pins.hold_latch_load) begin
            // transparent: follow the stages including a shift happening now
            hold_d = stage_d; // [R05]
        end
    end

    // ==========================================================
    // registers
    // ==========================================================
    // real part powers up unknown; reset gives a defined zero, yet the
    // controller must still load known bits before enabling (R10)
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stage_q    <= `SIPO_RESET_VAL; // [R10]
            hold_q     <= `SIPO_RESET_VAL;
            slow_q     <= 1'b0;
            clk_seen_q <= 1'b0;
        end else begin
            stage_q    <= stage_d;
            hold_q     <= hold_d;
            slow_q     <= slow_d;
            clk_seen_q <= pins.shift_clock;
        end
    end

    // ==========================================================
    // outputs
    // ==========================================================
    // latch data always present; enable decides whether the pins are driven
    assign parallel_outputs    = hold_q; // [R06]
    assign parallel_outputs_oe = pins.output_enable ? `SIPO_OE_ON : `SIPO_OE_OFF; // [R06] [R07]
    // last stage feeds the fast cascade, so a downstream part on the same
    // rising edge sees the pre-edge value of stage eight
    assign fast_cascade_out    = stage_q[`SIPO_LAST]; // [R03]
    assign slow_cascade_out    = slow_q; // [R04] [R09]

    // ==========================================================
    // assertions
    // ==========================================================
    // one rising edge moves every stage up by one and takes the new bit
    property p_shift;
        @(posedge clk) disable iff (!reset_n)
        sc_rise |=> stage_q == {$past(stage_q[`SIPO_LAST-1:`SIPO_FIRST]), $past(pins.serial_in)};
    endproperty
    a_shift: assert property (p_shift) // [R01]
        else $error("stages did not shift on rising edge");

    // the last stage, and with it the fast cascade, takes old stage seven
    property p_fast;
        @(posedge clk) disable iff (!reset_n)
        sc_rise |=> fast_cascade_out == $past(stage_q[`SIPO_SEVENTH]);
    endproperty
    a_fast: assert property (p_fast) // [R02]
        else $error("fast cascade not old stage seven");

    // between rising edges the fast cascade must not glitch, or a
    // downstream part clocked on the same edge could catch a wrong bit
    property p_fast_hold;
        @(posedge clk) disable iff (!reset_n)
        !sc_rise |=> $stable(stage_q) && $stable(fast_cascade_out);
    endproperty
    a_fast_hold: assert property (p_fast_hold) // [R03]
        else $error("stages moved without rising edge");

    // the slow cascade copies the fast one at the falling edge
    property p_slow_take;
        @(posedge clk) disable iff (!reset_n)
        sc_fall |=> slow_cascade_out == $past(fast_cascade_out);
    endproperty
    a_slow_take: assert property (p_slow_take) // [R04]
        else $error("slow cascade missed falling edge");

    // no falling edge, no change on the slow cascade
    property p_slow_keep;
        @(posedge clk) disable iff (!reset_n)
        !sc_fall |=> $stable(slow_cascade_out);
    endproperty
    a_slow_keep: assert property (p_slow_keep) // [R04]
        else $error("slow cascade changed off edge");

    // right after a falling edge both cascades carry the same bit
    property p_slow_match;
        @(posedge clk) disable iff (!reset_n)
        sc_fall |=> slow_cascade_out == fast_cascade_out;
    endproperty
    a_slow_match: assert property (p_slow_match) // [R04]
        else $error("slow cascade differs from fast after fall");

    // transparent latch: equal to the stages one clk after the strobe is high
    property p_latch_follow;
        @(posedge clk) disable iff (!reset_n)
        pins.hold_latch_load |=> parallel_outputs == stage_q;
    endproperty
    a_latch_follow: assert property (p_latch_follow) // [R05]
        else $error("latch not following stages");

    // a shift in the same clk as the strobe reaches the latch at once
    property p_latch_shift;
        @(posedge clk) disable iff (!reset_n)
        (pins.hold_latch_load && sc_rise)
        |=> parallel_outputs == {$past(stage_q[`SIPO_LAST-1:`SIPO_FIRST]), $past(pins.serial_in)};
    endproperty
    a_latch_shift: assert property (p_latch_shift) // [R05]
        else $error("latch missed shift during strobe");

    // strobe low: the latch keeps its value whatever the stages do
    property p_latch_keep;
        @(posedge clk) disable iff (!reset_n)
        !pins.hold_latch_load ##1 !pins.hold_latch_load |-> $stable(hold_q);
    endproperty
    a_latch_keep: assert property (p_latch_keep) // [R05]
        else $error("latch changed with strobe low");

    // enable high: every parallel driver is on
    property p_oe_on;
        @(posedge clk) disable iff (!reset_n)
        pins.output_enable |-> parallel_outputs_oe == `SIPO_OE_ON;
    endproperty
    a_oe_on: assert property (p_oe_on) // [R06]
        else $error("parallel outputs not driven");

    // enable low: every parallel driver is off
    property p_oe_off;
        @(posedge clk) disable iff (!reset_n)
        !pins.output_enable |-> parallel_outputs_oe == `SIPO_OE_OFF;
    endproperty
    a_oe_off: assert property (p_oe_off) // [R07]
        else $error("parallel outputs not floated");

    // the eight drivers switch as one group, never a mixed pattern
    property p_oe_group;
        @(posedge clk) disable iff (!reset_n)
        (parallel_outputs_oe == `SIPO_OE_ON) || (parallel_outputs_oe == `SIPO_OE_OFF);
    endproperty
    a_oe_group: assert property (p_oe_group) // [R07]
        else $error("parallel drivers not switched together");

    // an enable change alone leaves stages and latch untouched
    property p_oe_inert;
        @(posedge clk) disable iff (!reset_n)
        ($changed(pins.output_enable) && !sc_rise && !pins.hold_latch_load)
        |=> $stable(stage_q) && $stable(hold_q);
    endproperty
    a_oe_inert: assert property (p_oe_inert) // [R08]
        else $error("enable change altered state");

    // even with the strobe high, an enable change never moves the stages
    property p_oe_stage;
        @(posedge clk) disable iff (!reset_n)
        ($changed(pins.output_enable) && !sc_rise) |=> $stable(stage_q);
    endproperty
    a_oe_stage: assert property (p_oe_stage) // [R08]
        else $error("enable change moved the stages");

endmodule
`default_nettype wire

// *** pin_driver.sv ***
// controller model that drives the latch pins
`timescale 1ns/100ps
`default_nettype none
module pin_driver (
    input  wire logic                    clk,
    output var  sipo_latch_pkg::pin_in_s pins
);
    // ========
    // all pins low from time zero; latch content means nothing until loaded
    initial pins = '0;
    // strobe and enable move together, just after an edge
    task automatic set_ctl(input logic stb, input logic en);
        @(posedge clk);
        pins.hold_latch_load <= stb;
        pins.output_enable   <= en;
    endtask
    // high phase held n cycles; a long n mimics slow edges
    task automatic rise(input logic b, input int n);
        @(posedge clk);
        pins.serial_in   <= b;
        pins.shift_clock <= 1'b1;
        repeat (n) @(posedge clk);
    endtask
    // data no longer held once the clock falls, so show its inverse
    task automatic fall(input int n);
        @(posedge clk);
        pins.shift_clock <= 1'b0;
        pins.serial_in   <= ~pins.serial_in;
        repeat (n) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// *** serial_in_parallel_out_latch_tb.sv ***
// self-checking bench for the serial-in parallel-out latch
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module serial_in_parallel_out_latch_tb;
    logic                       clk = 1'b0;  // 200 MHz
    logic                       reset_n = 1'b0;
    sipo_latch_pkg::pin_in_s    pins;        // driven by the partner
    logic [7:0]                 par, oe;
    logic                       fast, slow;
    sipo_latch_pkg::stage_vec_t exp_sh, exp_lat;
    logic                       exp_fast, exp_slow, stb, en;
    logic [7:0]                 byte_v;
    int                         hold, n_fail, samples_checked;
    always #2.5 clk = ~clk;
    // expected stages after one rising shift-clock edge: new bit in bit 0
    function automatic sipo_latch_pkg::stage_vec_t shift_model(
        input sipo_latch_pkg::stage_vec_t s,
        input logic                       b);
        return {s[6:0], b};
    endfunction
    // expected driver enables: all eight pins switch together
    function automatic logic [7:0] oe_model(input logic e);
        return e ? 8'hFF : 8'h00;
    endfunction
    pin_driver pin_driver_i (.clk(clk), .pins(pins));
    serial_in_parallel_out_latch serial_in_parallel_out_latch_i (
        .clk(clk), .reset_n(reset_n), .pins(pins), .parallel_outputs(par),
        .parallel_outputs_oe(oe), .fast_cascade_out(fast), .slow_cascade_out(slow));
    // ========
    // single exit point for pass, fail and timeout
    task automatic end_of_test();
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // watchdog: far beyond the ~830 cycles the tests need
    initial begin
        #25000;
        n_fail++;
        end_of_test();
    end
    // ========
    // main sequence: reset, then rounds of shift, strobe and enable flips
    initial begin
        {exp_sh, exp_lat, exp_fast, exp_slow} = '0;
        void'($urandom(32'hBE7C));
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        for (int t = 0; t < 12; t++) begin
            // all-ones and all-zeros corners, random otherwise
            byte_v = (t == 1) ? 8'hFF : (t == 2) ? 8'h00 : 8'($urandom);
            hold = (t % 2 == 1) ? 4 : 2;
            stb = (t % 3 == 0);
            en = (t % 4 >= 2);
            pin_driver_i.set_ctl(stb, en);
            for (int k = 7; k >= 0; k--) begin
                pin_driver_i.rise(byte_v[k], hold);
                exp_fast = exp_sh[6];
                exp_sh = shift_model(exp_sh, byte_v[k]);
                if (stb) begin
                    exp_lat = exp_sh;
                end
                #1;
                `CHK("fast_cascade_out", exp_fast, fast)
                `CHK("slow_cascade_out", exp_slow, slow)
                pin_driver_i.fall(hold);
                exp_slow = exp_fast;
                #1;
                `CHK("slow_cascade_out", exp_slow, slow)
            end
            `CHK("parallel_outputs", exp_lat, par)
            `CHK("parallel_outputs_oe", oe_model(en), oe)
            // one strobe pulse while the enable flips
            pin_driver_i.set_ctl(1'b1, ~en);
            pin_driver_i.set_ctl(1'b0, ~en);
            repeat (2) @(posedge clk);
            exp_lat = exp_sh;
            #1;
            `CHK("parallel_outputs", exp_lat, par)
            `CHK("parallel_outputs_oe", oe_model(~en), oe)
            $display("test %0d done", t);
        end
        end_of_test();
    end
endmodule
`default_nettype wire
